// *** testbench/debug_session_control_sva.sv ***
// Checker of the debug session control block: bus readback, arming, trigger, tracing, routing and selects.
// Assumes it is bound to every instance of debug_session_control and sees its ports only.
`timescale 1ns/1ps
`include "debug_session_defines.vh"
module debug_session_control_sva (
    // Clock and reset.
    input wire        clk,
    input wire        resetn,
    // Register port.
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [7:0]  reg_rdata,
    // Sequencer, trace and system.
    input wire        trace_started,
    input wire        trace_done,
    input wire        trace_start,
    input wire        trace_enable,
    input wire        trigger_position,
    input wire        secured,
    input wire        background_mode_permit,
    input wire        seq_force_final,
    input wire        seq_restart,
    // Status, breakpoints and selects.
    input wire        armed,
    input wire [2:0]  sequencer_state_flags,
    input wire        break_to_bgnd,
    input wire        software_interrupt,
    input wire [2:0]  comp_bank_sel,
    input wire [3:0]  shared_sel
);
    wire ctl_wr = reg_write && reg_addr == `OFS_CONTROL_ONE;
    wire ctl_rd = reg_read && reg_addr == `OFS_CONTROL_ONE;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_arm_restart: assert property (ctl_wr && reg_wdata[7] && !armed |=> armed && seq_restart && sequencer_state_flags == 3'h1)
        else $error("arming did not restart the sequencer");
    chk_force_trigger_reads_zero: assert property (ctl_rd |=> reg_rdata[6:5] == 2'h0 && !reg_rdata[2])
        else $error("control readback shows a write-only bit");
    chk_arm_readback: assert property (ctl_rd |=> reg_rdata[7] == $past(armed))
        else $error("arm bit readback differs from armed");
    chk_select_match: assert property ($onehot(shared_sel) && shared_sel == {comp_bank_sel == 3'h0, comp_bank_sel})
        else $error("window and shared selects disagree");
    chk_force_trigger_final: assert property (ctl_wr && reg_wdata[6] && armed && sequencer_state_flags != 3'h4
        && !(trace_started && trigger_position) |=> seq_force_final)
        else $error("forced trigger did not reach the sequencer");
    chk_force_trigger_zero: assert property (ctl_wr && !reg_wdata[6] |=> !seq_force_final)
        else $error("zero trigger bit forced the final state");
    chk_force_trigger_aligned: assert property (ctl_wr && trace_started && trigger_position |=> !seq_force_final)
        else $error("trigger taken during trigger-first tracing");
    chk_secure_trace: assert property (secured |=> !trace_enable)
        else $error("tracing enabled while secured");
    chk_start_gated: assert property (trace_start |-> $past(trace_enable))
        else $error("trace started without tracing enabled");
    chk_auto_disarm: assert property (armed && trace_done && !ctl_wr |=> !armed && sequencer_state_flags == 3'h0)
        else $error("session not ended at trace completion");
    chk_break_single: assert property (!(break_to_bgnd && software_interrupt))
        else $error("breakpoint routed two ways at once");
    chk_bgnd_permit: assert property (break_to_bgnd |-> $past(background_mode_permit))
        else $error("background break without permission");
endmodule // debug_session_control_sva

bind debug_session_control debug_session_control_sva chk_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trace_started(trace_started), .trace_done(trace_done), .trace_start(trace_start), .trace_enable(trace_enable),
    .trigger_position(trigger_position), .secured(secured), .background_mode_permit(background_mode_permit),
    .seq_force_final(seq_force_final), .seq_restart(seq_restart), .armed(armed),
    .sequencer_state_flags(sequencer_state_flags), .break_to_bgnd(break_to_bgnd),
    .software_interrupt(software_interrupt), .comp_bank_sel(comp_bank_sel), .shared_sel(shared_sel));

// *** testbench/tb_debug_session_control.sv ***
// Self-checking bench of the debug session control block, one task for each scenario.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`include "debug_session_defines.vh"
module tb_debug_session_control;
    localparam [15:0] CTL = `OFS_CONTROL_ONE, STA = `OFS_STATE, TCR = `OFS_TRACE_CONTROL;
    reg        clk = 1'b0, resetn = 1'b0, por_resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    reg [15:0] reg_addr = 16'h0000;
    reg [7:0]  reg_wdata = 8'h00, shared_rdata = 8'h5a, window_rdata = 8'ha5;
    reg        seq_update = 1'b0, final_reached = 1'b0, trace_started = 1'b0, trace_done = 1'b0;
    reg        trace_full_event = 1'b0, secured = 1'b0, background_mode_permit = 1'b0, bgnd_active = 1'b0;
    reg [2:0]  seq_next_state = 3'h0;
    reg [5:0]  trace_line_count = 6'h00;
    wire [7:0] reg_rdata;
    wire       seq_force_final, seq_restart, trace_start, trace_enable, trigger_position, armed;
    wire       break_to_bgnd, software_interrupt;
    wire [1:0] trace_mode;
    wire [2:0] sequencer_state_flags, comp_bank_sel;
    wire [3:0] shared_sel;
    integer    errors = 0, checked = 0, n_ff = 0, n_ts = 0, n_bg = 0, n_sw = 0;

    debug_session_control DUT (.clk(clk), .resetn(resetn), .por_resetn(por_resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .shared_rdata(shared_rdata), .window_rdata(window_rdata), .seq_update(seq_update),
        .seq_next_state(seq_next_state), .final_reached(final_reached), .seq_force_final(seq_force_final),
        .seq_restart(seq_restart), .trace_started(trace_started), .trace_done(trace_done),
        .trace_full_event(trace_full_event), .trace_line_count(trace_line_count), .trace_start(trace_start),
        .trace_enable(trace_enable), .trigger_position(trigger_position), .trace_mode(trace_mode),
        .secured(secured), .background_mode_permit(background_mode_permit), .bgnd_active(bgnd_active),
        .armed(armed), .sequencer_state_flags(sequencer_state_flags), .break_to_bgnd(break_to_bgnd),
        .software_interrupt(software_interrupt), .comp_bank_sel(comp_bank_sel), .shared_sel(shared_sel));

    always #50 clk = ~clk;

    // Pulse counters let each scenario judge how many pulses its stimulus caused.
    always @(posedge clk) begin
        if (resetn) begin
            n_ff <= n_ff + seq_force_final;
            n_ts <= n_ts + trace_start;
            n_bg <= n_bg + break_to_bgnd;
            n_sw <= n_sw + software_interrupt;
        end
    end

    task summarize;
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task cmp(input string nm, input [7:0] exp, input [7:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task ticks(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task wr(input [15:0] a, input [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task rd(input string nm, input [15:0] a, input [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        cmp(nm, exp, reg_rdata);
    endtask

    task t_reset;
        rd("ctl", CTL, `RST_CONTROL_ONE);
        rd("tcr", TCR, `RST_TRACE_CONTROL);
        rd("stat", STA, 8'h00);
        rd("unmapped", 16'h0030, 8'h00);
        cmp("sel", 8'h11, {1'b0, comp_bank_sel, shared_sel});
    endtask

    task t_bank;
        integer c;
        for (c = 0; c < 4; c = c + 1) begin
            wr(CTL, 8'h80 | c[7:0]);
            ticks(1);
            cmp("bank", {1'b0, (c < 3) ? 3'h1 << c : 3'h0, 4'h1 << c}, {1'b0, comp_bank_sel, shared_sel});
            rd("shared", `OFS_SHARED, 8'h5a);
            if (c < 3)
                rd("window", `OFS_WINDOW_LAST, 8'ha5);
            else
                rd("window_none", `OFS_WINDOW_FIRST, 8'h00);
        end
        wr(CTL, 8'h00);
    endtask

    task t_lock;
        wr(CTL, 8'h99);
        rd("ctl", CTL, 8'h99);
        rd("stat", STA, 8'h01);
        wr(CTL, 8'h82);
        rd("ctl", CTL, 8'h9a);
        wr(TCR, 8'h4d);
        rd("tcr", TCR, 8'h00);
        @(posedge clk);
        seq_update <= 1'b1;
        seq_next_state <= 3'h2;
        @(posedge clk);
        seq_update <= 1'b0;
        wr(CTL, 8'h02);
        rd("ctl", CTL, 8'h1a);
        rd("stat", STA, 8'h02);
        wr(CTL, 8'h00);
        rd("ctl", CTL, 8'h00);
    endtask

    task t_force_trigger;
        integer f, s;
        f = n_ff;
        s = n_sw;
        wr(CTL, 8'h48);
        wr(CTL, 8'h88);
        wr(CTL, 8'h80);
        ticks(3);
        cmp("ff_idle", f[7:0], n_ff[7:0]);
        wr(CTL, 8'hc0);
        ticks(4);
        cmp("ff", f[7:0] + 8'h1, n_ff[7:0]);
        cmp("swi", s[7:0] + 8'h1, n_sw[7:0]);
        cmp("armed", 8'h00, {7'h0, armed});
        rd("stat", STA, 8'h00);
        wr(CTL, 8'h00);
    endtask

    task t_route;
        reg [5:0] tv [0:4];
        integer i, b, s;
        tv = '{6'h3a, 6'h35, 6'h11, 6'h1c, 6'h28};
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clk);
            background_mode_permit <= tv[i][3];
            bgnd_active <= tv[i][2];
            wr(CTL, {3'h0, tv[i][5:4], 3'h0});
            wr(CTL, {3'h4, tv[i][5:4], 3'h0});
            b = n_bg;
            s = n_sw;
            @(posedge clk);
            final_reached <= 1'b1;
            @(posedge clk);
            final_reached <= 1'b0;
            ticks(4);
            cmp("bgnd", b[7:0] + {7'h0, tv[i][1]}, n_bg[7:0]);
            cmp("swi", s[7:0] + {7'h0, tv[i][0]}, n_sw[7:0]);
            if (tv[i][1:0] != 2'h0 || !tv[i][4])
                cmp("armed", {7'h0, ~tv[i][4]}, {7'h0, armed});
            wr(CTL, 8'h00);
        end
    endtask

    task t_trace;
        integer t, s, f;
        wr(TCR, 8'h40);
        ticks(1);
        cmp("ten", 8'h01, {7'h0, trace_enable});
        wr(CTL, 8'h08);
        wr(CTL, 8'h88);
        t = n_ts;
        s = n_sw;
        wr(CTL, 8'hc0);
        ticks(3);
        cmp("tstart", t[7:0] + 8'h1, n_ts[7:0]);
        cmp("swi_wait", s[7:0], n_sw[7:0]);
        cmp("armed", 8'h01, {7'h0, armed});
        @(posedge clk);
        trace_done <= 1'b1;
        @(posedge clk);
        trace_done <= 1'b0;
        ticks(3);
        cmp("swi_end", s[7:0] + 8'h1, n_sw[7:0]);
        rd("stat", STA, 8'h00);
        wr(TCR, 8'h41);
        wr(CTL, 8'h88);
        f = n_ff;
        @(posedge clk);
        trace_started <= 1'b1;
        wr(CTL, 8'hc0);
        ticks(2);
        cmp("ff_ign", f[7:0], n_ff[7:0]);
        @(posedge clk);
        trace_started <= 1'b0;
        secured <= 1'b1;
        wr(CTL, 8'h88);
        t = n_ts;
        wr(CTL, 8'hc0);
        ticks(3);
        cmp("ten_sec", 8'h00, {7'h0, trace_enable});
        cmp("tstart_sec", t[7:0], n_ts[7:0]);
        @(posedge clk);
        secured <= 1'b0;
        wr(TCR, 8'h00);
        wr(CTL, 8'h88);
        wr(CTL, 8'hc0);
        ticks(3);
        cmp("tstart_off", t[7:0], n_ts[7:0]);
        wr(TCR, 8'h4d);
        rd("tcr_rw", TCR, 8'h4d);
        cmp("tcr_pins", 8'h07, {5'h0, trace_mode, trigger_position});
        wr(TCR, 8'h00);
        wr(CTL, 8'h00);
    endtask

    task t_full;
        wr(CTL, 8'h80);
        @(posedge clk);
        trace_full_event <= 1'b1;
        trace_line_count <= 6'h2a;
        @(posedge clk);
        trace_full_event <= 1'b0;
        wr(CTL, 8'h00);
        rd("stat", STA, 8'h81);
        rd("count", `OFS_LINE_COUNT, 8'haa);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        rd("stat_rst", STA, 8'h80);
        wr(CTL, 8'h80);
        rd("stat_arm", STA, 8'h01);
        @(posedge clk);
        trace_full_event <= 1'b1;
        @(posedge clk);
        trace_full_event <= 1'b0;
        resetn <= 1'b0;
        por_resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        por_resetn <= 1'b1;
        rd("stat_por", STA, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        por_resetn <= 1'b1;
        t_reset;
        t_bank;
        t_lock;
        t_force_trigger;
        t_route;
        t_trace;
        t_full;
        summarize;
    end

    initial begin
        #1000000;
        errors = errors + 1;
        summarize;
    end
endmodule // tb_debug_session_control

// *** verilog/break_router.v ***
// Registered routing of a breakpoint request to background mode or software interrupt.
// Assumes request is a one-cycle pulse from the control logic on the same clock.
`timescale 1ns/1ps
module break_router (
    // Clock and reset.
    input  wire clk,
    input  wire resetn,
    // Request and routing controls.
    input  wire request,
    input  wire target_bgnd,
    input  wire bgnd_permit,
    input  wire bgnd_active,
    // Routed pulses.
    output reg  bgnd_break,
    output reg  soft_int
);

always @(posedge clk) begin
    if (!resetn) begin
        bgnd_break <= 1'b0;
        soft_int   <= 1'b0;
    end else begin
        // Target set: background mode when permitted, else software interrupt.
        bgnd_break <= request & target_bgnd & bgnd_permit;
        // Target clear: interrupt only while background mode is inactive.
        soft_int   <= request & ((target_bgnd & ~bgnd_permit) | (~target_bgnd & ~bgnd_active));
    end
end

endmodule // break_router

// *** verilog/debug_session_control.v ***
// Control register logic of an on-chip debug module: arming, write lock, forced trigger,
// breakpoint generation and routing, and comparator bank visibility.
// Assumes the sequencer, comparators and trace buffer sit outside on the same clock.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "debug_session_defines.vh"
module debug_session_control (
    // Clock and resets.
    input  wire        clk,
    input  wire        resetn,
    input  wire        por_resetn,
    // Register port.
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    // External register read data.
    input  wire [7:0]  shared_rdata,
    input  wire [7:0]  window_rdata,
    // Sequencer.
    input  wire        seq_update,
    input  wire [2:0]  seq_next_state,
    input  wire        final_reached,
    output reg         seq_force_final,
    output reg         seq_restart,
    // Trace buffer.
    input  wire        trace_started,
    input  wire        trace_done,
    input  wire        trace_full_event,
    input  wire [5:0]  trace_line_count,
    output reg         trace_start,
    output reg         trace_enable,
    output reg         trigger_position,
    output reg  [1:0]  trace_mode,
    // System and background module.
    input  wire        secured,
    input  wire        background_mode_permit,
    input  wire        bgnd_active,
    // Status outputs.
    output reg         armed,
    output reg  [2:0]  sequencer_state_flags,
    // Breakpoint outputs.
    output wire        break_to_bgnd,
    output wire        software_interrupt,
    // Window selects.
    output wire [2:0]  comp_bank_sel,
    output wire [3:0]  shared_sel
);

// Registers.
reg        arm_reg;
reg        arm_next;
reg        break_target_select;
reg        break_target_next;
reg        break_request_enable;
reg        break_enable_next;
reg  [1:0] comparator_bank_select;
reg  [1:0] bank_next;
reg        trace_request;
reg        trace_request_next;
reg        force_trigger_pos_reg;
reg        force_trigger_pos_next;
reg  [1:0] mode_reg;
reg  [1:0] mode_next;
reg        trace_full_flag;
reg        full_next;
reg  [2:0] state_reg;
reg  [2:0] state_next;
reg        break_pending;
reg        pending_next;
reg        break_req;
reg        start_next;
reg        force_final_next;
reg  [7:0] rdata_next;

// Decoded accesses.
wire wr_ctrl   = reg_write && (reg_addr == `OFS_CONTROL_ONE);
wire wr_trace  = reg_write && (reg_addr == `OFS_TRACE_CONTROL);
wire arm_set   = wr_ctrl && reg_wdata[`BIT_ARM];
wire arm_clear = wr_ctrl && !reg_wdata[`BIT_ARM];
// Only a one written while disarmed starts a session; a one written while armed keeps it running.
wire arm_start = arm_set && !arm_reg;
// A zero in the force trigger bit is ignored; a one needs an armed session.
wire force_trigger_wr   = wr_ctrl && reg_wdata[`BIT_FORCE_TRIGGER] && arm_reg;
// Tracing runs only when requested and the system is not secured.
wire trace_on  = trace_request && !secured;
// A trigger-first trace already running makes the forced trigger a no-op.
wire force_trigger_take = force_trigger_wr && !(trace_started && force_trigger_pos_reg);
// Entry to the final state, from the sequencer or by force.
wire enter_final = arm_reg && (final_reached || force_trigger_take) && (state_reg != `SEQ_FINAL);

function [7:0] control_view;
    input       tgt;
    input       ena;
    input [1:0] bank;
    begin
        // Force trigger reads back as zero.
        control_view = 8'h00;
        control_view[`BIT_ARM]          = arm_reg;
        control_view[`BIT_BREAK_TARGET] = tgt;
        control_view[`BIT_BREAK_ENABLE] = ena;
        control_view[`BANK_HI:`BANK_LO] = bank;
    end
endfunction

function in_window;
    input [15:0] a;
    begin
        in_window = (a >= `OFS_WINDOW_FIRST) && (a <= `OFS_WINDOW_LAST);
    end
endfunction

// Next-state logic for the control and status registers.
always @* begin
    arm_next           = arm_reg;
    break_target_next  = break_target_select;
    break_enable_next  = break_request_enable;
    bank_next          = comparator_bank_select;
    trace_request_next = trace_request;
    force_trigger_pos_next      = force_trigger_pos_reg;
    mode_next          = mode_reg;
    state_next         = state_reg;
    pending_next       = break_pending;
    break_req          = 1'b0;
    start_next         = 1'b0;
    force_final_next   = 1'b0;
    if (wr_ctrl) begin
        // Bank select accepted in any state.
        bank_next = reg_wdata[`BANK_HI:`BANK_LO];
        // Target and enable change only while disarmed, so a disarming write keeps them.
        if (!arm_reg) begin
            break_target_next = reg_wdata[`BIT_BREAK_TARGET];
            break_enable_next = reg_wdata[`BIT_BREAK_ENABLE];
        end
    end
    // Trace control is locked while armed; the request bit also while secured.
    if (wr_trace && !arm_reg) begin
        if (!secured) begin
            trace_request_next = reg_wdata[`BIT_TRACE_REQUEST];
        end
        force_trigger_pos_next = reg_wdata[`BIT_FORCE_TRIGGER_POSITION];
        mode_next     = reg_wdata[`MODE_HI:`MODE_LO];
    end
    if (seq_update && arm_reg) begin
        state_next = seq_next_state;
    end
    if (enter_final) begin
        // Sequencer driven to its final state.
        state_next       = `SEQ_FINAL;
        force_final_next = force_trigger_take;
        if (trace_on) begin
            // With tracing, any breakpoint waits for the end of the trace.
            start_next   = !trace_started;
            pending_next = break_request_enable;
        end else if (break_request_enable) begin
            // Without tracing the breakpoint is immediate and ends the session.
            break_req  = 1'b1;
            arm_next   = 1'b0;
            state_next = `SEQ_DISARMED;
        end
    end
    if (trace_done && arm_reg) begin
        // Session ends with the trace; pending breakpoint issued now.
        arm_next     = 1'b0;
        state_next   = `SEQ_DISARMED;
        break_req    = break_pending && break_request_enable;
        pending_next = 1'b0;
    end
    if (arm_clear) begin
        // Software disarm keeps the last sequencer state.
        arm_next     = 1'b0;
        pending_next = 1'b0;
        state_next   = state_reg;
    end
    if (arm_start) begin
        // Arming restarts the sequencer; re-writing the arm bit while armed leaves the session alone,
        // so that a forced trigger written together with the arm bit still takes effect.
        arm_next     = 1'b1;
        state_next   = `SEQ_FIRST;
        pending_next = 1'b0;
        break_req    = 1'b0;
        start_next   = 1'b0;
    end
end

// Trace full flag: a fill event wins over the clearing arm write.
always @* begin
    full_next = trace_full_flag;
    if (arm_set) begin
        full_next = 1'b0;
    end
    if (trace_full_event) begin
        full_next = 1'b1;
    end
end

// Read data stand only in the cycle after the read strobe.
always @* begin
    rdata_next = 8'h00;
    if (reg_read) begin
        case (reg_addr)
            `OFS_CONTROL_ONE: begin
                rdata_next = control_view(break_target_select, break_request_enable, comparator_bank_select);
            end
            `OFS_STATE: begin
                rdata_next = {trace_full_flag, 4'h0, state_reg};
            end
            `OFS_TRACE_CONTROL: begin
                rdata_next = {1'b0, trace_request, 2'h0, mode_reg, 1'b0, force_trigger_pos_reg};
            end
            `OFS_LINE_COUNT: begin
                rdata_next = {trace_full_flag, 1'b0, trace_line_count};
            end
            `OFS_SHARED: begin
                // Outside logic supplies the register that the shared select names.
                rdata_next = shared_rdata;
            end
            default: begin
                // The window reads as zero when no comparator is mapped.
                if (in_window(reg_addr) && (comparator_bank_select != `BANK_NONE)) begin
                    rdata_next = window_rdata;
                end
            end
        endcase
    end
end

// Control registers on the ordinary reset.
always @(posedge clk) begin
    if (!resetn) begin
        arm_reg                <= 1'b0;
        break_target_select    <= 1'b0;
        break_request_enable   <= 1'b0;
        comparator_bank_select <= `BANK_A;
        trace_request          <= 1'b0;
        force_trigger_pos_reg           <= 1'b0;
        mode_reg               <= 2'h0;
        state_reg              <= `SEQ_DISARMED;
        break_pending          <= 1'b0;
        reg_rdata              <= 8'h00;
        seq_force_final        <= 1'b0;
        seq_restart            <= 1'b0;
        trace_start            <= 1'b0;
        trace_enable           <= 1'b0;
        trigger_position       <= 1'b0;
        trace_mode             <= 2'h0;
        armed                  <= 1'b0;
        sequencer_state_flags  <= `SEQ_DISARMED;
    end else begin
        arm_reg                <= arm_next;
        break_target_select    <= break_target_next;
        break_request_enable   <= break_enable_next;
        comparator_bank_select <= bank_next;
        trace_request          <= trace_request_next;
        force_trigger_pos_reg           <= force_trigger_pos_next;
        mode_reg               <= mode_next;
        state_reg              <= state_next;
        break_pending          <= pending_next;
        reg_rdata              <= rdata_next;
        seq_force_final        <= force_final_next;
        seq_restart            <= arm_start;
        trace_start            <= start_next;
        trace_enable           <= trace_request_next && !secured;
        trigger_position       <= force_trigger_pos_next;
        trace_mode             <= mode_next;
        armed                  <= arm_next;
        sequencer_state_flags  <= state_next;
    end
end

// The full flag survives every reset except power-on.
always @(posedge clk) begin
    if (!por_resetn) begin
        trace_full_flag <= 1'b0;
    end else begin
        trace_full_flag <= full_next;
    end
end

break_router u_break_router (
    .clk         (clk),
    .resetn      (resetn),
    .request     (break_req),
    .target_bgnd (break_target_select),
    .bgnd_permit (background_mode_permit),
    .bgnd_active (bgnd_active),
    .bgnd_break  (break_to_bgnd),
    .soft_int    (software_interrupt)
);

window_decoder u_window_decoder (
    .clk           (clk),
    .resetn        (resetn),
    .bank_code     (comparator_bank_select),
    .comp_bank_sel (comp_bank_sel),
    .shared_sel    (shared_sel)
);

endmodule // debug_session_control

// *** verilog/debug_session_defines.vh ***
// Offsets, field positions, reset values and codes of the debug session control block.
// Assumes an 8-bit register space reached by a 16-bit byte address.
`ifndef DEBUG_SESSION_DEFINES_VH
`define DEBUG_SESSION_DEFINES_VH

// Register offsets.
`define OFS_CONTROL_ONE    16'h0020
`define OFS_STATE          16'h0021
`define OFS_TRACE_CONTROL  16'h0022
`define OFS_LINE_COUNT     16'h0026
`define OFS_SHARED         16'h0027
`define OFS_WINDOW_FIRST   16'h0028
`define OFS_WINDOW_LAST    16'h002f

// Control register one fields.
`define BIT_ARM            7
`define BIT_FORCE_TRIGGER  6
`define BIT_BREAK_TARGET   4
`define BIT_BREAK_ENABLE   3
`define BANK_HI            1
`define BANK_LO            0

// Trace control register fields.
`define BIT_TRACE_REQUEST  6
`define MODE_HI            3
`define MODE_LO            2
`define BIT_FORCE_TRIGGER_POSITION  0

// Status and line count fields.
`define BIT_FULL           7

// Reset values.
`define RST_CONTROL_ONE    8'h00
`define RST_TRACE_CONTROL  8'h00

// Sequencer state flag codes.
`define SEQ_DISARMED       3'h0
`define SEQ_FIRST          3'h1
`define SEQ_FINAL          3'h4

// Bank select codes.
`define BANK_A             2'h0
`define BANK_B             2'h1
`define BANK_C             2'h2
`define BANK_NONE          2'h3

`endif

// *** verilog/window_decoder.v ***
// Registered decode of the comparator bank select code into window and shared address selects.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
`include "debug_session_defines.vh"
module window_decoder (
    // Clock and reset.
    input  wire       clk,
    input  wire       resetn,
    // Bank select code.
    input  wire [1:0] bank_code,
    // Decoded selects.
    output reg  [2:0] comp_bank_sel,
    output reg  [3:0] shared_sel
);

always @(posedge clk) begin
    if (!resetn) begin
        comp_bank_sel <= 3'h1;
        shared_sel    <= 4'h1;
    end else begin
        // One-hot comparator A, B or C; code for no comparator selects none.
        comp_bank_sel <= (bank_code == `BANK_NONE) ? 3'h0 : (3'h1 << bank_code);
        // Sequencer control one, two, three, or the match flag register.
        shared_sel    <= 4'h1 << bank_code;
    end
end

endmodule // window_decoder
